// ---- bench/eps_far.sv ----
/*
 * Far-side model: forwarding fabric feeding descriptors and the transmit MAC.
 * Assumes the bench fills pend, sets stall and slow, and reads got.
 */
`timescale 1ns/10ps
module eps_far (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Fabric side
    output reg         in_valid,
    output reg  [2:0]  in_prio,
    output reg  [10:0] in_len,
    input  wire        in_ready,
    // Transmit MAC side
    input  wire        tx_valid,
    input  wire [1:0]  tx_queue,
    output reg         tx_ready
);
    reg [13:0] pend[$];
    reg [1:0]  got[$];
    reg        stall = 1'b1;
    reg        slow = 1'b0;
    initial begin
        in_valid = 1'b0;
        in_prio = 3'h0;
        in_len = 11'h0;
        tx_ready = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got.push_back(tx_queue);
        tx_ready <= !stall && !(slow && tx_ready);
        if (rst) begin
            in_valid <= 1'b0;
        end else if (in_valid && !in_ready) begin
            in_valid <= 1'b1;
        end else if (pend.size() != 0 && in_ready) begin
            {in_prio, in_len} <= pend.pop_front();
            in_valid <= 1'b1;
        end else begin
            // Released lines toggle so a stale value never passes for a descriptor
            in_valid <= 1'b0;
            in_prio <= ~in_prio;
            in_len <= ~in_len;
        end
    end
endmodule // eps_far

// ---- bench/eps_props.sv ----
/*
 * Port checker for eps_sched: bus handshake, transmit hold, queue mapping and
 * receive gate. Assumes a bind from the bench top and the reset register values.
 */
`timescale 1ns/10ps
module eps_props (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Register bus
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Streams
    input wire        in_valid,
    input wire [2:0]  in_prio,
    input wire [10:0] in_len,
    input wire        in_ready,
    input wire        rx_ready,
    input wire        tx_valid,
    input wire [1:0]  tx_queue,
    input wire [10:0] tx_len,
    input wire        tx_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reg  [3:0] ctrl_q;
    reg  [1:0] free_q;
    wire       wr_ctrl = avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_byteenable[0];
    // Free counter lets the gate settle a few edges after a mode change
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= 4'he;
            free_q <= 2'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= avs_writedata[3:0];
            free_q <= (ctrl_q[3] || !ctrl_q[1]) ? free_q + {1'b0, free_q != 2'h3} : 2'h0;
        end
    end
    function automatic [1:0] qmap(input [2:0] p);
        qmap = (p == 3'h0 || p == 3'h3) ? 2'h1 : (p < 3'h3) ? 2'h0 : {1'b1, p[1]};
    endfunction
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_lone;
        !tx_valid && in_valid && in_ready ##1 !in_valid && !tx_valid;
    endsequence
    a_bus_wait: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("wait low without request");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_queue, tx_len}))
        else $error("transmit descriptor changed before accept");
    a_bad_addr: assert property (avs_read && avs_waitrequest && avs_address > 5'h10 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_read: assert property (
        avs_read && avs_waitrequest && avs_address == 5'h00 |=> avs_readdata == {28'h0, ctrl_q})
        else $error("control readback wrong");
    a_rx_free: assert property (free_q == 2'h3 |-> rx_ready)
        else $error("receive gate closed without ceiling");
    a_map_lone: assert property (s_lone |=> !tx_valid ||
        (tx_queue == qmap($past(in_prio, 2)) && tx_len == $past(in_len, 2)))
        else $error("descriptor in wrong queue");
    a_rst_quiet: assert property ($fell(rst) |-> !tx_valid && !in_ready && !rx_ready && avs_waitrequest)
        else $error("outputs active after reset");
endmodule // eps_props

// ---- bench/tb.sv ----
/*
 * Top bench for eps_sched: registers, mapping, scheduling modes, rate gates.
 * Assumes the far-side model eps_far and the checker eps_props.
 */
`timescale 1ns/10ps
module tb;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [4:0]  avs_address = 5'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  avs_byteenable = 4'hf;
    reg         rx_valid = 1'b0;
    reg  [10:0] rx_len = 11'h0;
    wire [31:0] avs_readdata;
    wire [10:0] in_len, tx_len;
    wire [2:0]  in_prio;
    wire [1:0]  tx_queue;
    wire        avs_waitrequest, in_valid, in_ready, rx_ready, tx_valid, tx_ready;
    integer     n_errors = 0, samples_checked = 0, cyc = 0;
    reg  [31:0] rd;
    localparam [15:0] q_map = {2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
    eps_sched i_eps_sched (.*);
    eps_far i_eps_far (.*);
    always #2 clk_sys = ~clk_sys;
    task end_sim;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t timeout", $time);
            end_sim;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
    endtask
    task bus(input w, input [4:0] a, input [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Queues fill while the MAC stalls, so after the first descriptor the order is fixed by the scheduler alone
    task load(input integer n, input [31:0] pl, input [10:0] l);
        for (int k = 0; k < n; k++) i_eps_far.pend.push_back({pl[3*k +: 3], l});
        while (i_eps_far.pend.size() != 0) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        i_eps_far.stall <= 1'b0;
    endtask
    task sched(input integer n, input [31:0] pl, input [31:0] exp, input [10:0] l);
        load(n, pl, l);
        for (int t = 0; t < 400 && i_eps_far.got.size() < n; t++) @(posedge clk_sys);
        for (int k = 0; k < n; k++) chk(i_eps_far.got[k], exp[2*k +: 2]);
        chk(i_eps_far.got.size(), n);
        i_eps_far.got.delete();
        i_eps_far.stall <= 1'b1;
        i_eps_far.slow <= 1'b0;
    endtask
    task rx_burst(input integer n, input [10:0] l);
        integer k;
        k = 0;
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_len <= l;
        while (k < n) begin
            @(posedge clk_sys);
            if (rx_ready === 1'b1) k = k + 1;
        end
        rx_valid <= 1'b0;
        rx_len <= ~l;
    endtask
    task t_regs;
        bus(0, 5'h00, 32'h0);
        chk(rd, 32'he);
        bus(0, 5'h04, 32'h0);
        chk(rd, 32'h64);
        bus(0, 5'h08, 32'h0);
        chk(rd, 32'h01010101);
        bus(1, 5'h14, 32'hffffffff);
        bus(0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        bus(1, 5'h04, 32'hffffffff);
        bus(0, 5'h04, 32'h0);
        chk(rd, 32'h3ff);
    endtask
    task t_rate;
        integer lo;
        lo = 0;
        bus(1, 5'h04, 32'h3e8);
        bus(1, 5'h00, 32'h2);
        sched(4, {3'h6, 3'h6, 3'h6, 3'h6}, 8'hff, 11'h7ff);
        rx_burst(3, 11'h7ff);
        rx_burst(1, 11'h1f4);
        repeat (3000) begin
            @(posedge clk_sys);
            if (rx_ready === 1'b0) lo = lo + 1;
            else if (lo > 0) break;
        end
        chk(lo >= 995 && lo <= 1004, 1);
        bus(1, 5'h00, 32'ha);
        rx_burst(3, 11'h7ff);
        repeat (4) @(posedge clk_sys);
        chk(rx_ready, 1);
        bus(1, 5'h00, 32'h4);
        load(4, {3'h6, 3'h6, 3'h6, 3'h6}, 11'h7ff);
        repeat (400) @(posedge clk_sys);
        chk(i_eps_far.got.size() < 4, 1);
        chk(rx_ready, 1);
    endtask
    initial begin
        do_reset;
        t_regs;
        for (int p = 0; p < 8; p++) sched(1, p, {30'h0, q_map[2*p +: 2]}, 11'h040);
        sched(6, {3'h7, 3'h2, 3'h6, 3'h4, 3'h0, 3'h1}, {2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0}, 11'h040);
        bus(0, 5'h10, 32'h0);
        chk(rd, 32'he);
        bus(0, 5'h0c, 32'h0);
        chk(rd, 32'h000c0000);
        bus(1, 5'h10, 32'h0);
        bus(0, 5'h10, 32'h0);
        chk(rd, 32'h0);
        do_reset;
        bus(1, 5'h00, 32'h1);
        bus(1, 5'h08, 32'h03020101);
        sched(10, {3'h1, 3'h0, 3'h0, 3'h4, 3'h4, 3'h4, 3'h6, 3'h6, 3'h6, 3'h6},
              {2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3}, 11'h040);
        bus(1, 5'h08, 32'h02020202);
        i_eps_far.slow <= 1'b1;
        sched(8, {3'h1, 3'h0, 3'h4, 3'h6, 3'h1, 3'h0, 3'h4, 3'h6},
              {2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3}, 11'h040);
        bus(1, 5'h08, 32'h01010001);
        sched(6, {3'h1, 3'h0, 3'h0, 3'h0, 3'h4, 3'h6}, {2'h0, 2'h2, 2'h1, 2'h1, 2'h1, 2'h3}, 11'h040);
        t_rate;
        end_sim;
    end
endmodule // tb
bind eps_sched eps_props i_eps_props (.*);

// ---- design/eps_rate_lim.v ----
/*
 * Credit-based rate limiter for one traffic direction.
 * Assumes the caller spends only while pass_ok is high.
 */
`timescale 1ns/10ps
`include "eps_sched_regs.vh"

module eps_rate_lim (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Configuration
    input  wire        limit_en,
    input  wire [9:0]  rate_mbps,
    // Spending
    input  wire        spend,
    input  wire [10:0] spend_len,
    // Permission
    output wire        pass_ok
);
    localparam [12:0]        BYTE_COST = `EPS_BYTE_COST;
    localparam signed [25:0] CAP       = `EPS_CREDIT_CAP;

    reg  signed [24:0] credit_q;
    reg  signed [25:0] credit_d;
    reg                pass_ok_q;
    wire [23:0]        cost;

    // Rate in Mbit/s at 250 MHz: one byte costs 8*250 units, each cycle earns rate units
    assign cost = spend ? spend_len * BYTE_COST : 24'h0;

    always @* begin
        credit_d = {credit_q[24], credit_q} + $signed({16'h0, rate_mbps}) - $signed({2'b00, cost});
        if (credit_d > CAP) begin
            credit_d = CAP; // Burst capped at one longest packet
        end
        if (!limit_en) begin
            credit_d = CAP;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            credit_q  <= 25'h0;
            pass_ok_q <= 1'b1;
        end else begin
            credit_q  <= credit_d[24:0];
            pass_ok_q <= ~limit_en | ~credit_d[25];
        end
    end

    assign pass_ok = pass_ok_q;

endmodule // eps_rate_lim

// ---- design/eps_sched.v ----
/*
 * Egress priority scheduler for one switch port: four descriptor queues,
 * strict or weighted round-robin draining, and receive/transmit rate ceilings.
 * Assumes descriptors from the forwarding fabric and a transmit path that
 * takes one descriptor per valid/ready handshake; registers on Avalon-MM.
 */
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "eps_sched_regs.vh"

module eps_sched (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Tagged packets from the fabric
    input  wire        in_valid,
    input  wire [2:0]  in_prio,
    input  wire [10:0] in_len,
    output wire        in_ready,
    // Receive path gate
    input  wire        rx_valid,
    input  wire [10:0] rx_len,
    output wire        rx_ready,
    // Transmit path
    output wire        tx_valid,
    output wire [1:0]  tx_queue,
    output wire [10:0] tx_len,
    input  wire        tx_ready
);
    localparam [1:0] QUEUE_LOWEST  = 2'h0;
    localparam [1:0] QUEUE_LOW     = 2'h1;
    localparam [1:0] QUEUE_HIGH    = 2'h2;
    localparam [1:0] QUEUE_HIGHEST = 2'h3;

    // Register file
    reg  [31:0] ctrl_q;
    reg  [9:0]  rate_q;
    reg  [31:0] weight_q;
    reg  [31:0] txcnt_q;
    reg  [31:0] readdata_q;
    reg         waitreq_q;
    reg  [31:0] rd_mux;

    // Scheduler state
    reg  [8:0]  pass_q;
    reg  [8:0]  pass_d;
    reg  [1:0]  ptr_q;
    reg  [1:0]  ptr_d;
    reg         load;
    reg  [1:0]  pick;
    reg         tx_valid_q;
    reg  [1:0]  tx_queue_q;
    reg  [10:0] tx_len_q;
    reg         in_ready_q;
    reg         rx_ready_q;

    wire [3:0]  nonempty;
    wire [3:0]  room;
    wire [3:0]  zero_hit;
    wire [3:0]  cand_cur;
    wire [3:0]  cand_nxt;
    wire [3:0]  cand_any;
    wire [15:0] counts;
    wire [43:0] heads;
    wire [1:0]  in_queue;
    wire        push_ok;
    wire        slot_free;
    wire        tx_ok;
    wire        rx_ok;
    wire        rx_take;
    wire        wr_hit;
    wire        mode_wrr;
    wire [31:0] ctrl_new;
    wire [31:0] rate_new;

    assign mode_wrr = ctrl_q[`EPS_CTRL_WRR];
    assign push_ok  = in_valid & in_ready_q;
    assign rx_take  = rx_valid & rx_ready_q;
    assign wr_hit   = avs_write & ~waitreq_q;
    assign slot_free = ~tx_valid_q | tx_ready;
    assign ctrl_new  = merge_be(ctrl_q, avs_writedata, avs_byteenable);
    assign rate_new  = merge_be({22'h0, rate_q}, avs_writedata, avs_byteenable);

    function [1:0] map_prio;
        input [2:0] prio;
        begin
            case (prio)
                3'h0, 3'h3: map_prio = QUEUE_LOW;
                3'h1, 3'h2: map_prio = QUEUE_LOWEST;
                3'h4, 3'h5: map_prio = QUEUE_HIGH;
                default:    map_prio = QUEUE_HIGHEST;
            endcase
        end
    endfunction

    function [1:0] highest;
        input [3:0] mask;
        begin
            if (mask[3]) begin
                highest = 2'h3;
            end else if (mask[2]) begin
                highest = 2'h2;
            end else if (mask[1]) begin
                highest = 2'h1;
            end else begin
                highest = 2'h0;
            end
        end
    endfunction

    function [31:0] merge_be;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  be;
        integer      b;
        begin
            merge_be = old_val;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge_be[8*b +: 8] = new_val[8*b +: 8];
                end
            end
        end
    endfunction

    assign in_queue = map_prio(in_prio);

    // Four descriptor queues, 3 highest down to 0 lowest
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_queue
            localparam [1:0] QI = i;
            reg  [10:0] mem_q [0:7];
            reg  [2:0]  wr_ptr_q;
            reg  [2:0]  rd_ptr_q;
            reg  [3:0]  cnt_q;
            wire        push;
            wire        pop;
            wire [7:0]  w;
            wire [8:0]  w9;

            assign push = push_ok & (in_queue == QI);
            assign pop  = load & (pick == QI);
            assign w    = weight_q[8*i +: 8];
            assign w9   = {1'b0, w};

            always @(posedge clk_sys) begin
                if (rst) begin
                    wr_ptr_q <= 3'h0;
                    rd_ptr_q <= 3'h0;
                    cnt_q    <= 4'h0;
                end else begin
                    if (push) begin
                        wr_ptr_q <= wr_ptr_q + 3'h1;
                    end
                    if (pop) begin
                        rd_ptr_q <= rd_ptr_q + 3'h1;
                    end
                    cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop};
                end
            end

            always @(posedge clk_sys) begin
                if (push) begin
                    mem_q[wr_ptr_q] <= in_len;
                end
            end

            assign nonempty[i]       = (cnt_q != 4'h0);
            // Ready is registered, so leave room for one push in flight
            assign room[i]           = (cnt_q <= `EPS_QROOM);
            assign counts[4*i +: 4]  = cnt_q;
            assign heads[11*i +: 11] = mem_q[rd_ptr_q];
            assign zero_hit[i] = nonempty[i] & (w == 8'h00);
            assign cand_cur[i] = nonempty[i] & (w != 8'h00) & (w9 >= pass_q) & (QI <= ptr_q);
            assign cand_nxt[i] = nonempty[i] & (w9 > pass_q);
            assign cand_any[i] = nonempty[i] & (w != 8'h00);
        end
    endgenerate

    // Pick the next queue; at most one descriptor per cycle
    always @* begin
        load   = 1'b0;
        pick   = 2'h0;
        pass_d = pass_q;
        ptr_d  = ptr_q;
        if (slot_free & tx_ok) begin
            if (!mode_wrr) begin
                if (|nonempty) begin
                    load = 1'b1;
                    pick = highest(nonempty);
                end
                pass_d = 9'h001;
                ptr_d  = 2'h3;
            end else if (|zero_hit) begin
                load = 1'b1;
                pick = highest(zero_hit);
            end else if (|cand_any) begin
                load = 1'b1;
                if (|cand_cur) begin
                    pick = highest(cand_cur);
                end else if (|cand_nxt) begin
                    pick   = highest(cand_nxt);
                    pass_d = pass_q + 9'h001;
                end else begin
                    pick   = highest(cand_any);
                    pass_d = 9'h001;
                end
                if (pick == 2'h0) begin
                    ptr_d  = 2'h3;
                    pass_d = pass_d + 9'h001;
                end else begin
                    ptr_d = pick - 2'h1;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            pass_q     <= 9'h001;
            ptr_q      <= 2'h3;
            tx_valid_q <= 1'b0;
            tx_queue_q <= 2'h0;
            tx_len_q   <= 11'h000;
            in_ready_q <= 1'b0;
            rx_ready_q <= 1'b0;
        end else begin
            pass_q     <= pass_d;
            ptr_q      <= ptr_d;
            in_ready_q <= &room;
            rx_ready_q <= rx_ok;
            if (load) begin
                tx_valid_q <= 1'b1;
                tx_queue_q <= pick;
                tx_len_q   <= heads[11*pick +: 11];
            end else if (tx_ready) begin
                tx_valid_q <= 1'b0;
            end
        end
    end

    // Rate ceilings; unlimited overrides both directions
    eps_rate_lim u_tx_lim (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .limit_en  (ctrl_q[`EPS_CTRL_DIR_TX] & ~ctrl_q[`EPS_CTRL_UNLIM]),
        .rate_mbps (rate_q),
        .spend     (load),
        .spend_len (heads[11*pick +: 11]),
        .pass_ok   (tx_ok)
    );

    eps_rate_lim u_rx_lim (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .limit_en  (ctrl_q[`EPS_CTRL_DIR_RX] & ~ctrl_q[`EPS_CTRL_UNLIM]),
        .rate_mbps (rate_q),
        .spend     (rx_take),
        .spend_len (rx_len),
        .pass_ok   (rx_ok)
    );

    // Register read mux; unmapped offsets read zero
    always @* begin
        case (avs_address)
            `EPS_REG_CTRL:   rd_mux = {28'h0, ctrl_q[3:0]};
            `EPS_REG_RATE:   rd_mux = {22'h0, rate_q};
            `EPS_REG_WEIGHT: rd_mux = weight_q;
            `EPS_REG_STATUS: rd_mux = {12'h0, rx_ok, tx_ok, tx_queue_q, counts};
            `EPS_REG_TXCNT:  rd_mux = txcnt_q;
            default:         rd_mux = 32'h0;
        endcase
    end

    // One wait cycle per access: data is staged on the same edge that waitrequest drops
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q     <= `EPS_CTRL_RST;
            rate_q     <= `EPS_RATE_RST;
            weight_q   <= `EPS_WEIGHT_RST;
            txcnt_q    <= 32'h0;
            readdata_q <= 32'h0;
            waitreq_q  <= 1'b1;
        end else begin
            waitreq_q <= ~((avs_read | avs_write) & waitreq_q);
            if (avs_read & waitreq_q) begin
                readdata_q <= rd_mux;
            end
            if (wr_hit && avs_address == `EPS_REG_CTRL) begin
                ctrl_q <= {28'h0, ctrl_new[3:0]};
            end
            if (wr_hit && avs_address == `EPS_REG_RATE) begin
                rate_q <= rate_new[9:0];
            end
            if (wr_hit && avs_address == `EPS_REG_WEIGHT) begin
                weight_q <= merge_be(weight_q, avs_writedata, avs_byteenable);
            end
            // A clearing write in the same cycle as a count restarts the counter at one
            if (load) begin
                txcnt_q <= (wr_hit && avs_address == `EPS_REG_TXCNT) ? 32'h1 : txcnt_q + 32'h1;
            end else if (wr_hit && avs_address == `EPS_REG_TXCNT) begin
                txcnt_q <= 32'h0;
            end
        end
    end

    assign avs_readdata    = readdata_q;
    assign avs_waitrequest = waitreq_q;
    assign in_ready        = in_ready_q;
    assign rx_ready        = rx_ready_q;
    assign tx_valid        = tx_valid_q;
    assign tx_queue        = tx_queue_q;
    assign tx_len          = tx_len_q;

endmodule // eps_sched

// ---- design/eps_sched_regs.vh ----
/*
 * Register map, field positions, reset values and timing constants of the
 * egress priority scheduler. Assumes a 32-bit Avalon-MM slave with byte
 * addresses and a single 250 MHz core clock.
 */
// Operation
// - Each port keeps four packet queues, 3 highest down to 0 lowest.
// - Priorities 0,3 go to queue 1; 1,2 to 0; 4,5 to 2; 6,7 to 3.
// - Strict mode sends from the highest non-empty queue only.
// - Weighted mode: one packet per queue per pass, weight w joins first w passes.
// - Equal weights give plain round-robin.
// - Zero-weight queue is drained to empty before nonzero-weight queues resume.
// - Bandwidth ceiling applies to receive, transmit or both per direction setting.
// - Limited direction runs at the configured rate in Mbit/s.
// - Unlimited option removes the ceiling whatever the rate.
`ifndef EPS_SCHED_REGS_VH
`define EPS_SCHED_REGS_VH

// Register byte offsets
`define EPS_REG_CTRL       5'h00
`define EPS_REG_RATE       5'h04
`define EPS_REG_WEIGHT     5'h08
`define EPS_REG_STATUS     5'h0c
`define EPS_REG_TXCNT      5'h10

// Control fields
`define EPS_CTRL_WRR       0
`define EPS_CTRL_DIR_RX    1
`define EPS_CTRL_DIR_TX    2
`define EPS_CTRL_UNLIM     3

// Reset values
`define EPS_CTRL_RST       32'h0000000e
`define EPS_RATE_RST       10'h064
`define EPS_WEIGHT_RST     32'h01010101

// Queue geometry
`define EPS_QDEPTH         4'h8
`define EPS_QROOM          4'h6

// Timing: clock rate, and the credit cost of one byte in rate-units per cycle
`define EPS_CLK_MHZ        250
`define EPS_BYTE_COST      (8 * `EPS_CLK_MHZ)
`define EPS_MAX_LEN        2047
`define EPS_CREDIT_CAP     (`EPS_MAX_LEN * `EPS_BYTE_COST)

`endif
